/* File: include/sprc_params.svh */
/*
  Constants of the sleep and power reduction controller: register offsets,
  field positions, reset values and timing counts.
  Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register port.
*/
`ifndef SPRC_PARAMS_SVH
`define SPRC_PARAMS_SVH

`define SPRC_CLK_PERIOD_NS     40
`define SPRC_OFF_SLEEP_CTRL    8'h00
`define SPRC_OFF_PWR_RED       8'h04
`define SPRC_OFF_MCU_CTRL      8'h08
`define SPRC_OFF_DIDR_A        8'h0c
`define SPRC_OFF_DIDR_B        8'h10
`define SPRC_OFF_STATUS        8'h14

`define SPRC_SE_BIT            0
`define SPRC_SM_LSB            1
`define SPRC_SM_MSB            3
`define SPRC_PR_TIMER16        3
`define SPRC_PR_SPI            2
`define SPRC_PR_UART           1
`define SPRC_PR_CONV           0
`define SPRC_PR_MASK           8'h0f
`define SPRC_JTD_BIT           0
`define SPRC_REG_RESET         8'h00

`define SPRC_SM_IDLE           3'h0
`define SPRC_SM_ADC_NR         3'h1
`define SPRC_SM_PWR_DOWN       3'h2
`define SPRC_SM_PWR_SAVE       3'h3
`define SPRC_SM_STANDBY        3'h6

`define SPRC_HALT_CYCLES       16'h0004
`define SPRC_STANDBY_CYCLES    16'h0006
`define SPRC_OSC_STARTUP_NS    640
`define SPRC_VREF_STARTUP_NS   70000
`define SPRC_BOD_OFF_CODE      3'h7

`define SPRC_RESP_OKAY         2'h0
`define SPRC_RESP_SLVERR       2'h2

`endif

/* File: include/sprc_pkg.sv */
/*
  Types of the sleep and power reduction controller.
  Assumes sprc_params.svh is compiled with it.
*/
package sprc_pkg;

  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SLEEPING,
    ST_WAKE_START,
    ST_WAKE_HALT
  } sprc_state_type;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic main_osc;
    logic timer_osc;
    logic timer16;
    logic spi;
    logic uart;
    logic conv;
  } sprc_gate_type;

  typedef struct packed {
    logic adc_powered;
    logic comp_enable;
    logic comp_mux_allow;
    logic vref_enable;
    logic vref_ready;
    logic bod_enable;
    logic wdt_run;
    logic adc_extended;
    logic jtag_enable;
    logic tdo_oe;
    logic tdo_o;
  } sprc_analog_type;

endpackage

/* File: rtl/sprc_ctrl.sv */
/*
  Sleep-mode and power-reduction controller with its AXI4-Lite register port.
  Assumes all inputs synchronous to aclk; clock gates are enables for the
  clock tree cells outside this block, which owns no gated clock itself.
*/
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "sprc_params.svh"

module sprc_ctrl #(
  parameter int OSC_STARTUP_CYCLES  = (`SPRC_OSC_STARTUP_NS + `SPRC_CLK_PERIOD_NS - 1) / `SPRC_CLK_PERIOD_NS,
  parameter int VREF_STARTUP_CYCLES = (`SPRC_VREF_STARTUP_NS + `SPRC_CLK_PERIOD_NS - 1) / `SPRC_CLK_PERIOD_NS
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [7:0]              s_axi_araddr,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  input  wire logic                    sleep_instr,
  input  wire logic                    wake_irq,
  input  wire logic                    adc_enable,
  input  wire logic                    adc_conv_start,
  input  wire logic                    comparator_disable_bit,
  input  wire logic                    comparator_uses_bandgap,
  input  wire logic                    watchdog_enable,
  input  wire logic [2:0]              brownout_level_fuse,
  input  wire logic                    debug_enable_fuse,
  input  wire logic                    jtag_enable_fuse,
  input  wire logic                    tap_shifting,
  input  wire logic                    tap_tdo,
  input  wire logic [15:0]             wake_pin_mask,
  output logic                         cpu_halted,
  output sprc_pkg::sprc_gate_type      clock_gates,
  output sprc_pkg::sprc_analog_type    analog_ctrl,
  output logic [15:0]                  input_buffer_en
);
  import sprc_pkg::*;

  typedef struct packed {
    sprc_state_type  state;
    logic [2:0]      mode;
    logic [15:0]     count;
    logic [7:0]      sleep_ctrl;
    logic [7:0]      pwr_red;
    logic [7:0]      mcu_ctrl;
    logic [7:0]      didr_a;
    logic [7:0]      didr_b;
    logic            aw_have;
    logic [7:0]      aw_addr;
    logic            w_have;
    logic [7:0]      w_data;
    logic            w_strb0;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic            adc_prev;
    logic            vref_prev;
    logic [15:0]     vref_cnt;
    sprc_gate_type   gates;
    sprc_analog_type analog;
    logic [15:0]     ibuf;
    logic            halted;
  } sprc_regs_type;

  sprc_regs_type st_q;
  sprc_regs_type st_d;

  // Register index 0..5 for a mapped word, 7 for anything else
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    case (addr)
      `SPRC_OFF_SLEEP_CTRL: reg_index = 3'h0;
      `SPRC_OFF_PWR_RED:    reg_index = 3'h1;
      `SPRC_OFF_MCU_CTRL:   reg_index = 3'h2;
      `SPRC_OFF_DIDR_A:     reg_index = 3'h3;
      `SPRC_OFF_DIDR_B:     reg_index = 3'h4;
      `SPRC_OFF_STATUS:     reg_index = 3'h5;
      default:              reg_index = 3'h7;
    endcase
  endfunction

  // Only the five documented codes are real modes
  function automatic logic mode_valid(input logic [2:0] m);
    mode_valid = (m == `SPRC_SM_IDLE) || (m == `SPRC_SM_ADC_NR) || (m == `SPRC_SM_PWR_DOWN) ||
                 (m == `SPRC_SM_PWR_SAVE) || (m == `SPRC_SM_STANDBY);
  endfunction

  logic [2:0]  sel_mode;
  logic        sleeping;
  logic        osc_hold;
  logic        bod_on;
  logic        comp_bg;
  logic        adc_on;
  logic        vref_on;
  logic        wr_fire;
  logic [2:0]  wr_idx;
  logic [2:0]  rd_idx;
  logic [31:0] rd_word;

  always_comb begin
    st_d     = st_q;
    sel_mode = st_q.sleep_ctrl[`SPRC_SM_MSB:`SPRC_SM_LSB];
    sleeping = (st_q.state == ST_SLEEPING) || (st_q.state == ST_WAKE_START);

    // Power state sequence
    case (st_q.state)
      ST_ACTIVE: begin
        if (sleep_instr && st_q.sleep_ctrl[`SPRC_SE_BIT] && mode_valid(sel_mode)) begin
          st_d.state = ST_SLEEPING;
          st_d.mode  = sel_mode;
        end
      end
      ST_SLEEPING: begin
        if (wake_irq) begin
          st_d.state = ST_WAKE_START;
          case (st_q.mode)
            `SPRC_SM_PWR_DOWN, `SPRC_SM_PWR_SAVE: st_d.count = 16'(OSC_STARTUP_CYCLES);
            `SPRC_SM_STANDBY:                     st_d.count = `SPRC_STANDBY_CYCLES;
            default:                              st_d.count = 16'h0001;
          endcase
        end
      end
      ST_WAKE_START: begin
        // Oscillator restart time, then the fixed halt
        if (st_q.count <= 16'h0001) begin
          st_d.state = ST_WAKE_HALT;
          st_d.count = `SPRC_HALT_CYCLES;
        end else begin
          st_d.count = st_q.count - 16'h0001;
        end
      end
      ST_WAKE_HALT: begin
        if (st_q.count <= 16'h0001) begin
          st_d.state = ST_ACTIVE;
          st_d.count = 16'h0000;
        end else begin
          st_d.count = st_q.count - 16'h0001;
        end
      end
      default: begin
        st_d.state = ST_ACTIVE;
      end
    endcase

    // Clock domains per sleep mode
    st_d.gates = '0;
    osc_hold   = debug_enable_fuse && jtag_enable_fuse && !st_q.mcu_ctrl[`SPRC_JTD_BIT];
    if (!sleeping) begin
      st_d.gates.cpu       = (st_q.state == ST_ACTIVE);
      st_d.gates.flash     = (st_q.state == ST_ACTIVE);
      st_d.gates.io        = 1'b1;
      st_d.gates.adc       = 1'b1;
      st_d.gates.asy       = 1'b1;
      st_d.gates.main_osc  = 1'b1;
      st_d.gates.timer_osc = 1'b1;
    end else begin
      case (st_q.mode)
        `SPRC_SM_IDLE: begin
          st_d.gates.io        = 1'b1;
          st_d.gates.adc       = 1'b1;
          st_d.gates.asy       = 1'b1;
          st_d.gates.main_osc  = 1'b1;
          st_d.gates.timer_osc = 1'b1;
        end
        `SPRC_SM_ADC_NR: begin
          st_d.gates.adc       = 1'b1;
          st_d.gates.asy       = 1'b1;
          st_d.gates.main_osc  = 1'b1;
          st_d.gates.timer_osc = 1'b1;
        end
        `SPRC_SM_PWR_DOWN: begin
          st_d.gates.main_osc  = osc_hold || (st_q.state == ST_WAKE_START);
        end
        `SPRC_SM_PWR_SAVE: begin
          st_d.gates.asy       = 1'b1;
          st_d.gates.timer_osc = 1'b1;
          st_d.gates.main_osc  = osc_hold || (st_q.state == ST_WAKE_START);
        end
        `SPRC_SM_STANDBY: begin
          st_d.gates.main_osc  = 1'b1;
        end
        default: begin
          st_d.gates.main_osc  = 1'b1;
        end
      endcase
    end
    // Stopped timer, SPI and UART freeze in place, so clearing their bit resumes them as they were; the converter bit also powers the ADC down
    st_d.gates.timer16 = st_d.gates.io && !st_q.pwr_red[`SPRC_PR_TIMER16];
    st_d.gates.spi     = st_d.gates.io && !st_q.pwr_red[`SPRC_PR_SPI];
    st_d.gates.uart    = st_d.gates.io && !st_q.pwr_red[`SPRC_PR_UART];
    st_d.gates.conv    = st_d.gates.adc && !st_q.pwr_red[`SPRC_PR_CONV];

    // Analog enables; sleep does not touch the ADC, the detector or the watchdog
    bod_on  = (brownout_level_fuse != `SPRC_BOD_OFF_CODE);
    adc_on  = adc_enable && !st_q.pwr_red[`SPRC_PR_CONV];
    comp_bg = comparator_uses_bandgap && !comparator_disable_bit;
    vref_on = bod_on || comp_bg || adc_on;
    st_d.analog.adc_powered    = adc_on;
    st_d.analog.comp_mux_allow = !st_q.pwr_red[`SPRC_PR_CONV];
    st_d.analog.comp_enable    = !comparator_disable_bit &&
                                 (!sleeping || st_q.mode == `SPRC_SM_IDLE || st_q.mode == `SPRC_SM_ADC_NR);
    st_d.analog.vref_enable    = vref_on;
    st_d.analog.bod_enable     = bod_on;
    st_d.analog.wdt_run        = watchdog_enable;
    st_d.vref_prev             = vref_on;

    // Reference start-up: a reference that never dropped stays ready
    if (!vref_on) begin
      st_d.vref_cnt          = 16'h0000;
      st_d.analog.vref_ready = 1'b0;
    end else if (!st_q.vref_prev) begin
      st_d.vref_cnt          = 16'(VREF_STARTUP_CYCLES);
      st_d.analog.vref_ready = 1'b0;
    end else if (st_q.vref_cnt > 16'h0001) begin
      st_d.vref_cnt          = st_q.vref_cnt - 16'h0001;
    end else begin
      st_d.vref_cnt          = 16'h0000;
      st_d.analog.vref_ready = 1'b1;
    end

    // Extended conversion after an off/on cycle; a new switch-off beats the start
    st_d.adc_prev = adc_on;
    if (st_q.adc_prev && !adc_on) begin
      st_d.analog.adc_extended = 1'b1;
    end else if (adc_conv_start && adc_on) begin
      st_d.analog.adc_extended = 1'b0;
    end

    // JTAG and TDO
    st_d.analog.jtag_enable = jtag_enable_fuse && !st_q.mcu_ctrl[`SPRC_JTD_BIT];
    st_d.analog.tdo_oe      = st_d.analog.jtag_enable && tap_shifting;
    st_d.analog.tdo_o       = tap_tdo;

    // Pin input buffers
    for (int i = 0; i < 16; i++) begin
      st_d.ibuf[i] = !((i < 8) ? st_q.didr_a[i] : st_q.didr_b[i - 8]);
    end
    if (!st_d.gates.io && !st_d.gates.adc) begin
      st_d.ibuf = st_d.ibuf & wake_pin_mask;
    end
    st_d.halted = (st_q.state != ST_ACTIVE); // Same lag as the gates, so halt and core clock agree

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && !st_q.aw_have && !st_q.bvalid) begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_have && !st_q.bvalid) begin
      st_d.w_have  = 1'b1;
      st_d.w_data  = s_axi_wdata[7:0];
      st_d.w_strb0 = s_axi_wstrb[0];
    end
    wr_fire = st_q.aw_have && st_q.w_have && !st_q.bvalid;
    wr_idx  = reg_index(st_q.aw_addr);
    if (wr_fire) begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = (wr_idx == 3'h7) ? `SPRC_RESP_SLVERR : `SPRC_RESP_OKAY;
      if (st_q.w_strb0) begin
        case (wr_idx)
          3'h0:    st_d.sleep_ctrl = st_q.w_data & 8'h0f;
          3'h1:    st_d.pwr_red    = st_q.w_data & `SPRC_PR_MASK;
          3'h2:    st_d.mcu_ctrl   = st_q.w_data & 8'h01;
          3'h3:    st_d.didr_a     = st_q.w_data;
          3'h4:    st_d.didr_b     = st_q.w_data;
          default: st_d.bvalid     = 1'b1;
        endcase
      end
    end else if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // Read channel
    rd_idx  = reg_index(s_axi_araddr);
    rd_word = 32'h0000_0000;
    case (rd_idx)
      3'h0:    rd_word[7:0] = st_q.sleep_ctrl;
      3'h1:    rd_word[7:0] = st_q.pwr_red & `SPRC_PR_MASK;
      3'h2:    rd_word[7:0] = st_q.mcu_ctrl;
      3'h3:    rd_word[7:0] = st_q.didr_a;
      3'h4:    rd_word[7:0] = st_q.didr_b;
      3'h5:    rd_word[7:0] = {st_q.analog.vref_ready, st_q.analog.vref_enable, st_q.analog.adc_extended,
                               st_q.analog.jtag_enable, st_q.mode, st_q.state != ST_ACTIVE};
      default: rd_word      = 32'h0000_0000;
    endcase
    if (s_axi_arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = rd_word;
      st_d.rresp  = (rd_idx == 3'h7) ? `SPRC_RESP_SLVERR : `SPRC_RESP_OKAY;
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q            <= '0;
      st_q.state      <= ST_ACTIVE;
      st_q.sleep_ctrl <= `SPRC_REG_RESET;
      st_q.pwr_red    <= `SPRC_REG_RESET;
      st_q.mcu_ctrl   <= `SPRC_REG_RESET;
      st_q.didr_a     <= `SPRC_REG_RESET;
      st_q.didr_b     <= `SPRC_REG_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Handshake outputs straight from state; data from flip-flops
  assign s_axi_awready   = !st_q.aw_have && !st_q.bvalid;
  assign s_axi_wready    = !st_q.w_have && !st_q.bvalid;
  assign s_axi_bvalid    = st_q.bvalid;
  assign s_axi_bresp     = st_q.bresp;
  assign s_axi_arready   = !st_q.rvalid;
  assign s_axi_rvalid    = st_q.rvalid;
  assign s_axi_rdata     = st_q.rdata;
  assign s_axi_rresp     = st_q.rresp;
  assign cpu_halted      = st_q.halted;
  assign clock_gates     = st_q.gates;
  assign analog_ctrl     = st_q.analog;
  assign input_buffer_en = st_q.ibuf;

endmodule

/* File: tb/sprc_ctrl_asserts.sv */
/* Concurrent checks on the ports of the sleep and power reduction controller.
   Bound to every sprc_ctrl instance; one clock aclk, synchronous low reset. */
`timescale 1ns/1ps
module sprc_ctrl_asserts (
  input wire logic                      aclk, aresetn, sleep_instr, cpu_halted, adc_enable,
  input wire logic                      s_axi_arvalid, s_axi_arready, s_axi_rvalid, watchdog_enable,
  input wire logic                      tap_shifting, jtag_enable_fuse, comparator_uses_bandgap,
  input wire logic [7:0]                s_axi_araddr,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic [1:0]                s_axi_rresp,
  input wire logic [2:0]                brownout_level_fuse,
  input wire sprc_pkg::sprc_gate_type   clock_gates,
  input wire sprc_pkg::sprc_analog_type analog_ctrl
);
  logic [7:0] rd_addr_q;
  logic       halt_run;
  // Address of the read now answered; arready low while rvalid keeps it valid
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_addr_q <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_addr_q <= s_axi_araddr;
  end
  assign halt_run = cpu_halted && clock_gates.io && !clock_gates.cpu;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_pr_reserved;
    s_axi_rvalid && rd_addr_q == 8'h04 |-> s_axi_rdata[31:4] == 28'h0;
  endproperty
  a_pr_reserved: assert property (p_pr_reserved) else $error("reserved bits not zero");
  property p_sleep_cause;
    $rose(cpu_halted) |-> $past(sleep_instr, 2);
  endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("halt without sleep");
  // Last four halted cycles run peripherals with the core still stopped
  property p_wake_halt;
    $fell(cpu_halted) |-> clock_gates.cpu && $past(halt_run, 1) && $past(halt_run, 4);
  endproperty
  a_wake_halt: assert property (p_wake_halt) else $error("wake halt wrong");
  property p_bod_on;
    brownout_level_fuse != 3'h7 |=> analog_ctrl.bod_enable && analog_ctrl.vref_enable;
  endproperty
  a_bod_on: assert property (p_bod_on) else $error("detector or reference off");
  property p_vref_off;
    brownout_level_fuse == 3'h7 && !adc_enable && !comparator_uses_bandgap |=> !analog_ctrl.vref_enable;
  endproperty
  a_vref_off: assert property (p_vref_off) else $error("reference on unused");
  property p_wdt;
    watchdog_enable |=> analog_ctrl.wdt_run;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog stopped");
  property p_tdo_float;
    !tap_shifting |=> !analog_ctrl.tdo_oe;
  endproperty
  a_tdo_float: assert property (p_tdo_float) else $error("tdo driven");
  property p_jtag_fuse;
    !jtag_enable_fuse |=> !analog_ctrl.jtag_enable;
  endproperty
  a_jtag_fuse: assert property (p_jtag_fuse) else $error("jtag left on");
  c_wake: cover property ($fell(cpu_halted));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_ext: cover property (analog_ctrl.adc_extended);
endmodule

bind sprc_ctrl sprc_ctrl_asserts chk (.*);

/* File: tb/sprc_ctrl_bench.sv */
/* Self-checking bench for the sleep and power reduction controller.
   Drives every port itself; short start-up counts keep the run brief. */
`timescale 1ns/1ps
module sprc_ctrl_bench;
  import sprc_pkg::*;
  localparam int OSC = 4;
  logic            aclk = 1'b0;
  logic            aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic            s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_instr, wake_irq, adc_enable;
  logic            adc_conv_start, comparator_disable_bit, comparator_uses_bandgap, watchdog_enable;
  logic            debug_enable_fuse, jtag_enable_fuse, tap_shifting, tap_tdo, cpu_halted;
  logic [7:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata, d, e;
  logic [3:0]      s_axi_wstrb;
  logic [1:0]      s_axi_bresp, s_axi_rresp;
  logic [2:0]      brownout_level_fuse;
  logic [15:0]     wake_pin_mask, input_buffer_en;
  sprc_gate_type   clock_gates;
  sprc_analog_type analog_ctrl;
  int              n_mismatch, check_count, i;
  logic [2:0]      modes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  logic [2:0]      bad [4] = '{3'h0, 3'h4, 3'h5, 3'h7};

  sprc_ctrl #(.OSC_STARTUP_CYCLES(OSC), .VREF_STARTUP_CYCLES(4)) dut (.*);

  always #20 aclk = ~aclk;

  function automatic int f_wake(input logic [2:0] m);
    if (m == 3'h2 || m == 3'h3) return OSC + 6;
    return (m == 3'h6) ? 12 : 7;
  endfunction

  task complete_run;
    $display("Mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task tmo(input string m);
    n_mismatch++;
    $display("CHECK FAILED at %0t: timeout %s", $time, m);
    complete_run();
  endtask

  // Ready is looked at mid-cycle, where it is settled for the next edge
  task axi_write(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st, input logic [1:0] er);
    logic ta, tw, got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= st;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 50 && !got; k++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      got = s_axi_bvalid;
      if (got) chk(s_axi_bresp === er, "write response");
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (got) s_axi_bready <= 1'b0;
    end
    if (!got) tmo("write");
  endtask

  task axi_read(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    logic ta, got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 50 && !got; k++) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      got = s_axi_rvalid;
      if (got) chk(s_axi_rdata === ev && s_axi_rresp === er, "read data");
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (got) s_axi_rready <= 1'b0;
    end
    if (!got) tmo("read");
  endtask

  task sleep_go(input logic [2:0] m, input logic se);
    axi_write(8'h00, {28'h0, m, se}, 4'hf, 2'h0);
    @(posedge aclk);
    sleep_instr <= 1'b1;
    @(posedge aclk);
    sleep_instr <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
  endtask

  task wake(input int exp);
    int n;
    n = 0;
    @(posedge aclk);
    wake_irq <= 1'b1;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (cpu_halted === 1'b1 && n < 200);
    chk(n == exp, "wake cycles");
    @(posedge aclk);
    wake_irq <= 1'b0;
    axi_write(8'h00, 32'h0, 4'hf, 2'h0);
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleep_instr, wake_irq} = '0;
    {adc_conv_start, comparator_disable_bit, comparator_uses_bandgap, debug_enable_fuse} = '0;
    {tap_shifting, tap_tdo, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {aresetn, adc_enable, watchdog_enable, jtag_enable_fuse} = 4'h7;
    brownout_level_fuse = 3'h4;
    n_mismatch = 0;
    check_count = 0;
    d = $urandom(9);
    wake_pin_mask = 16'($urandom);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 5; i++) axi_read(8'(i * 4), 32'h0, 2'h0);
    axi_read(8'h20, 32'h0, 2'h2);
    axi_write(8'h20, 32'hff, 4'hf, 2'h2);
    adc_enable <= 1'b0;
    for (i = 0; i < 7; i++) begin
      d = (i == 0) ? 32'hff : $urandom;
      axi_write(8'h04, d, 4'hf, 2'h0);
      axi_read(8'h04, {28'h0, d[3:0]}, 2'h0);
      #1;
      chk({clock_gates.timer16, clock_gates.spi, clock_gates.uart, clock_gates.conv} === ~d[3:0], "clock stop");
      chk(analog_ctrl.comp_mux_allow === ~d[0], "comparator mux");
    end
    axi_write(8'h04, 32'h0, 4'hf, 2'h0);
    brownout_level_fuse <= 3'h7;
    repeat (3) @(posedge aclk);
    #1;
    chk(analog_ctrl.vref_enable === 1'b0 && analog_ctrl.adc_extended === 1'b1, "reference off");
    @(posedge aclk);
    adc_enable <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    chk(analog_ctrl.vref_enable === 1'b1 && analog_ctrl.vref_ready === 1'b0, "reference start");
    for (i = 0; i < 20 && analog_ctrl.vref_ready !== 1'b1; i++) @(posedge aclk);
    if (i == 20) tmo("reference");
    @(posedge aclk);
    adc_conv_start <= 1'b1;
    @(posedge aclk);
    adc_conv_start <= 1'b0;
    @(posedge aclk);
    #1;
    chk(analog_ctrl.adc_extended === 1'b0, "extended cleared");
    axi_read(8'h14, 32'hd0, 2'h0);
    comparator_uses_bandgap <= 1'b1;
    adc_enable <= 1'b0;
    sleep_go(3'h2, 1'b1);
    chk(analog_ctrl.vref_enable === 1'b1 && analog_ctrl.comp_enable === 1'b0, "bandgap in sleep");
    comparator_disable_bit <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    chk(analog_ctrl.vref_enable === 1'b0, "reference released");
    wake(f_wake(3'h2));
    {comparator_disable_bit, comparator_uses_bandgap, adc_enable} <= 3'b001;
    brownout_level_fuse <= 3'h4;
    // Reference must be settled before sleeping, else ready reads low
    repeat (8) @(posedge aclk);
    foreach (modes[k]) begin
      sleep_go(modes[k], 1'b1);
      chk(cpu_halted === 1'b1 && clock_gates.cpu === 1'b0, "sleep entered");
      chk(clock_gates.io === (modes[k] == 3'h0) && clock_gates.adc === (modes[k] < 3'h2), "sleep clocks");
      chk(clock_gates.main_osc === (modes[k] < 3'h2 || modes[k] == 3'h6), "oscillator");
      chk(analog_ctrl.comp_enable === (modes[k] < 3'h2), "comparator off");
      chk(clock_gates.flash === 1'b0 && clock_gates.asy === (modes[k] inside {3'h0, 3'h1, 3'h3}) &&
          clock_gates.timer_osc === (modes[k] inside {3'h0, 3'h1, 3'h3}), "async clocks");
      chk(&{analog_ctrl.adc_powered, analog_ctrl.bod_enable, analog_ctrl.wdt_run, analog_ctrl.vref_ready} === 1'b1,
          "kept on");
      chk(input_buffer_en === ((modes[k] < 3'h2) ? 16'hffff : wake_pin_mask), "input buffers");
      wake(f_wake(modes[k]));
    end
    foreach (bad[k]) begin
      sleep_go(bad[k], bad[k] != 3'h0);
      chk(cpu_halted === 1'b0, "sleep refused");
    end
    d = $urandom;
    e = $urandom;
    axi_write(8'h0c, d, 4'hf, 2'h0);
    axi_write(8'h10, e, 4'hf, 2'h0);
    axi_read(8'h10, {24'h0, e[7:0]}, 2'h0);
    #1;
    chk(input_buffer_en === ~{e[7:0], d[7:0]}, "input disable");
    debug_enable_fuse <= 1'b1;
    sleep_go(3'h2, 1'b1);
    chk(clock_gates.main_osc === 1'b1, "debug oscillator");
    wake(f_wake(3'h2));
    axi_write(8'h08, 32'h1, 4'hf, 2'h0);
    sleep_go(3'h3, 1'b1);
    chk(clock_gates.main_osc === 1'b0 && analog_ctrl.jtag_enable === 1'b0, "jtag disabled");
    wake(f_wake(3'h3));
    axi_write(8'h08, 32'h0, 4'hf, 2'h0);
    {tap_shifting, tap_tdo} <= 2'b11;
    repeat (2) @(posedge aclk);
    #1;
    chk(analog_ctrl.tdo_oe === 1'b1 && analog_ctrl.tdo_o === 1'b1, "tdo driven");
    tap_shifting <= 1'b0;
    jtag_enable_fuse <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
    chk(analog_ctrl.tdo_oe === 1'b0 && analog_ctrl.jtag_enable === 1'b0, "tdo float, fuse off");
    complete_run();
  end
endmodule
